// ---- logic/frontend_irq_defines.vh ----
`ifndef FRONTEND_IRQ_DEFINES_VH
`define FRONTEND_IRQ_DEFINES_VH

// ----------------------------------------
// Register indices, byte address is index * 4
// ----------------------------------------
`define IDX_ENABLE 6'h01
`define IDX_STATUS 6'h02
`define IDX_CLEAR 6'h03
`define IDX_XCV_CTRL 6'h04

// ----------------------------------------
// Event bit positions
// ----------------------------------------
`define EVT_W 20
`define B_RX_END 0
`define B_TX_END 1
`define B_IDLE 2
`define B_MOD_FOUND 3
`define B_CARD_ACT 4
`define B_STATE_CHG 5
`define B_EXT_OFF 6
`define B_EXT_ON 7
`define B_OWN_OFF 8
`define B_OWN_ON 9
`define B_FIELD_FAULT 10
`define B_TIMER0 11
`define B_TIMER1 12
`define B_TIMER2 13
`define B_SOF_SEEN 14
`define B_SC_SEEN 15
`define B_TEMP_FAULT 16
`define B_GEN_ERROR 17
`define B_NVM_FAIL 18
`define B_LPCD 19

// ----------------------------------------
// Enable layout and reset values
// ----------------------------------------
`define EN_FIXED_MASK 20'hE_0000
`define EN_RW_MASK 20'h1_FFFF
`define EN_RESET 20'h0_0000
`define STAT_RESET 20'h0_0000

// ----------------------------------------
// Trigger select field and transceive states
// ----------------------------------------
`define TRIG_LSB 4
`define TRIG_MSB 9
`define TRIG_W 6
`define TRIG_RESET 6'h00
`define ST_IDLE 3'h0
`define ST_WAIT_TX 3'h1
`define ST_TXING 3'h2
`define ST_WAIT_RX 3'h3
`define ST_WAIT_DATA 3'h4
`define ST_RXING 3'h5

// ----------------------------------------
// Bus answers
// ----------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- logic/frontend_irq_logic.v ----
// Behaviour
// - A set status bit reaches the irq pin only when its enable bit is 1.
// - Enable bits 19, 18, 17 are read-only and always read 1.
// - Enable bits 0 to 16 are read/write and reset to 0.
// - Enable layout: rx end 0, tx end 1, idle 2, modulation 3, card 4, state 5.
// - Status bits 0 to 19 read-only, reset 0; bits 31:20 reserved, read 0.
// - Status: temperature 16, general error 17, memory program fail 18, card detect 19.
// - Status: timers 11, 12, 13; frame start 14; subcarrier 15.
// - Status: external field off 6, on 7; own field off 8, on 9; fault 10.
// - Status bit 1 on end of transmission, bit 0 on end of reception.
// - Status bit 2 on idle, 3 on modulation found, 4 on card activation.
// - Writing a one to a clear register bit resets that status bit.
// - State change flag only on entry to a state selected in the trigger field.
//
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none
`include "frontend_irq_defines.vh"

module frontend_irq_logic (
    input wire clk,
    input wire rst_n,
    input wire [7:0] address,
    input wire read,
    input wire write,
    input wire [31:0] writedata,
    input wire [3:0] byteenable,
    output reg [31:0] readdata,
    output reg [1:0] response,
    output wire waitrequest,
    input wire rx_end_evt,
    input wire tx_end_evt,
    input wire idle_evt,
    input wire modulation_found_evt,
    input wire card_activated_evt,
    input wire ext_field_off_evt,
    input wire ext_field_on_evt,
    input wire own_field_off_evt,
    input wire own_field_on_evt,
    input wire field_activity_fault_evt,
    input wire timer_zero_evt,
    input wire timer_one_evt,
    input wire timer_two_evt,
    input wire frame_start_seen_evt,
    input wire subcarrier_seen_evt,
    input wire temp_fault_evt,
    input wire general_error_evt,
    input wire nvm_program_fail_evt,
    input wire low_power_card_detect_evt,
    input wire [2:0] xcv_state,
    output reg irq
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Merge new data into old data on the enabled byte lanes only
    function [31:0] lane_merge;
        input [31:0] old_val;
        input [31:0] new_val;
        input [3:0] lanes;
        integer i;
        begin
            lane_merge = old_val;
            for (i = 0; i < 4; i = i + 1) begin
                if (lanes[i]) begin
                    lane_merge[i*8 +: 8] = new_val[i*8 +: 8];
                end
            end
        end
    endfunction

    // Word index match on an aligned byte address
    function hit;
        input [7:0] addr;
        input [5:0] idx;
        begin
            hit = (addr[7:2] == idx) && (addr[1:0] == 2'h0);
        end
    endfunction

    // ----------------------------------------
    // Bus handshake
    // ----------------------------------------
    // One wait cycle: read data is registered in the first cycle and the
    // write commits at the edge where waitrequest is seen low.
    reg done_q;
    reg done_d;
    wire req;
    wire take;
    wire commit_wr;
    wire sel_enable;
    wire sel_status;
    wire sel_clear;
    wire sel_ctrl;
    wire mapped;

    assign req = read | write;
    assign take = req & ~done_q;
    assign waitrequest = take;
    assign commit_wr = write & done_q;
    assign sel_enable = hit(address, `IDX_ENABLE);
    assign sel_status = hit(address, `IDX_STATUS);
    assign sel_clear = hit(address, `IDX_CLEAR);
    assign sel_ctrl = hit(address, `IDX_XCV_CTRL);
    assign mapped = sel_enable | sel_status | sel_clear | sel_ctrl;

    // Back-to-back requests get a fresh wait cycle because done drops here
    always @* begin
        done_d = take;
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            done_q <= 1'b0;
        end else begin
            done_q <= done_d;
        end
    end

    // ----------------------------------------
    // Enable mask and trigger select
    // ----------------------------------------
    reg [`EVT_W-1:0] enable_q;
    reg [`EVT_W-1:0] enable_d;
    reg [`TRIG_W-1:0] trig_sel_q;
    reg [`TRIG_W-1:0] trig_sel_d;
    wire [`EVT_W-1:0] enable_eff;
    wire [31:0] enable_merged;
    wire [31:0] ctrl_merged;

    assign enable_eff = enable_q | `EN_FIXED_MASK;
    assign enable_merged = lane_merge({12'h000, enable_q}, writedata, byteenable);
    assign ctrl_merged = lane_merge({22'h00_0000, trig_sel_q, 4'h0}, writedata, byteenable);

    // A write lands only at the edge where the master sees waitrequest low
    always @* begin
        enable_d = enable_q;
        trig_sel_d = trig_sel_q;
        if (commit_wr && sel_enable) begin
            // Fixed bits are never stored, so they cannot be turned off
            enable_d = enable_merged[`EVT_W-1:0] & `EN_RW_MASK;
        end
        if (commit_wr && sel_ctrl) begin
            trig_sel_d = ctrl_merged[`TRIG_MSB:`TRIG_LSB];
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_q <= `EN_RESET;
            trig_sel_q <= `TRIG_RESET;
        end else begin
            enable_q <= enable_d;
            trig_sel_q <= trig_sel_d;
        end
    end

    // ----------------------------------------
    // State change detection
    // ----------------------------------------
    reg [2:0] prev_state_q;
    reg [2:0] prev_state_d;
    reg state_entry;

    // Remembering the last state turns a level into a one-cycle entry event
    always @* begin
        prev_state_d = xcv_state;
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_state_q <= `ST_IDLE;
        end else begin
            prev_state_q <= prev_state_d;
        end
    end

    // Codes above the receiving state select nothing
    always @* begin
        state_entry = 1'b0;
        if (xcv_state != prev_state_q) begin
            case (xcv_state)
                `ST_IDLE: state_entry = trig_sel_q[0];
                `ST_WAIT_TX: state_entry = trig_sel_q[1];
                `ST_TXING: state_entry = trig_sel_q[2];
                `ST_WAIT_RX: state_entry = trig_sel_q[3];
                `ST_WAIT_DATA: state_entry = trig_sel_q[4];
                `ST_RXING: state_entry = trig_sel_q[5];
                default: state_entry = 1'b0;
            endcase
        end
    end

    // ----------------------------------------
    // Event vector
    // ----------------------------------------
    reg [`EVT_W-1:0] events;

    always @* begin
        events = `STAT_RESET;
        events[`B_RX_END] = rx_end_evt;
        events[`B_TX_END] = tx_end_evt;
        events[`B_IDLE] = idle_evt;
        events[`B_MOD_FOUND] = modulation_found_evt;
        events[`B_CARD_ACT] = card_activated_evt;
        events[`B_STATE_CHG] = state_entry;
        events[`B_EXT_OFF] = ext_field_off_evt;
        events[`B_EXT_ON] = ext_field_on_evt;
        events[`B_OWN_OFF] = own_field_off_evt;
        events[`B_OWN_ON] = own_field_on_evt;
        events[`B_FIELD_FAULT] = field_activity_fault_evt;
        events[`B_TIMER0] = timer_zero_evt;
        events[`B_TIMER1] = timer_one_evt;
        events[`B_TIMER2] = timer_two_evt;
        events[`B_SOF_SEEN] = frame_start_seen_evt;
        events[`B_SC_SEEN] = subcarrier_seen_evt;
        events[`B_TEMP_FAULT] = temp_fault_evt;
        events[`B_GEN_ERROR] = general_error_evt;
        events[`B_NVM_FAIL] = nvm_program_fail_evt;
        events[`B_LPCD] = low_power_card_detect_evt;
    end

    // ----------------------------------------
    // Sticky status
    // ----------------------------------------
    // A set arriving together with its clear wins, so no event is lost
    reg [`EVT_W-1:0] status_q;
    reg [`EVT_W-1:0] status_d;
    wire [`EVT_W-1:0] clear_bits;
    wire [31:0] clear_word;

    assign clear_word = lane_merge(32'h0000_0000, writedata, byteenable);
    assign clear_bits = (commit_wr && sel_clear) ? clear_word[`EVT_W-1:0] : `STAT_RESET;

    // Clear first, then set: an event in the clearing cycle survives
    always @* begin
        status_d = (status_q & ~clear_bits) | events;
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= `STAT_RESET;
        end else begin
            status_q <= status_d;
        end
    end

    // ----------------------------------------
    // Interrupt pin
    // ----------------------------------------
    // Registered so the pin never glitches while status and mask settle
    reg irq_d;

    always @* begin
        irq_d = |(status_q & enable_eff);
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= irq_d;
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    // Status is read only: writes to it are accepted and dropped. The clear
    // register acts as a pulse and always reads back zero.
    reg [31:0] readdata_d;
    reg [1:0] response_d;
    wire [31:0] enable_word;
    wire [31:0] status_word;
    wire [31:0] ctrl_word;

    assign enable_word = {12'h000, enable_eff};
    assign status_word = {12'h000, status_q};
    assign ctrl_word = {22'h00_0000, trig_sel_q, 4'h0};

    // Data is captured in the wait cycle and then held, so the master may
    // sample it at its own edge without the registers being read twice
    always @* begin
        readdata_d = readdata;
        response_d = response;
        if (take) begin
            response_d = mapped ? `RESP_OKAY : `RESP_SLVERR;
            readdata_d = 32'h0000_0000;
            if (read && sel_enable) begin
                readdata_d = enable_word;
            end else if (read && sel_status) begin
                readdata_d = status_word;
            end else if (read && sel_ctrl) begin
                readdata_d = ctrl_word;
            end
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            readdata <= 32'h0000_0000;
            response <= `RESP_OKAY;
        end else begin
            readdata <= readdata_d;
            response <= response_d;
        end
    end

endmodule

`default_nettype wire

// ---- tb/frontend_irq_asserts.sv ----
`timescale 1ns/1ns
`default_nettype none
module frontend_irq_asserts (
    input wire clk,
    input wire rst_n,
    input wire [7:0] address,
    input wire read,
    input wire write,
    input wire [31:0] writedata,
    input wire [3:0] byteenable,
    input wire [31:0] readdata,
    input wire waitrequest,
    input wire irq,
    input wire rx_end_evt,
    input wire idle_evt,
    input wire own_field_on_evt,
    input wire timer_zero_evt,
    input wire frame_start_seen_evt,
    input wire temp_fault_evt,
    input wire general_error_evt,
    input wire nvm_program_fail_evt,
    input wire low_power_card_detect_evt
);
    // ----------------------------------------
    // Shadow of the writable enables
    // ----------------------------------------
    // Follows the byte lanes, since the bench writes partial words too
    logic [16:0] en_q;
    wire wc = write && !waitrequest;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            en_q <= 17'h0_0000;
        end else if (wc && address == 8'h04) begin
            if (byteenable[0]) en_q[7:0] <= writedata[7:0];
            if (byteenable[1]) en_q[15:8] <= writedata[15:8];
            if (byteenable[2]) en_q[16] <= writedata[16];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_fixed_irq: assert property (
        (general_error_evt || nvm_program_fail_evt || low_power_card_detect_evt) |=> ##1 irq)
        else $error("fixed event did not raise irq");
    chk_timer_gate: assert property (timer_zero_evt && en_q[11] |=> ##1 irq)
        else $error("timer event did not raise irq");
    chk_temp_gate: assert property (temp_fault_evt && en_q[16] |=> ##1 irq)
        else $error("temperature event did not raise irq");
    chk_rx_irq: assert property (rx_end_evt && en_q[0] |=> ##1 irq)
        else $error("rx end did not raise irq");
    chk_idle_irq: assert property (idle_evt && en_q[2] |=> ##1 irq)
        else $error("idle did not raise irq");
    chk_field_irq: assert property (own_field_on_evt && en_q[9] |=> ##1 irq)
        else $error("field on did not raise irq");
    chk_sof_irq: assert property (frame_start_seen_evt && en_q[14] |=> ##1 irq)
        else $error("frame start did not raise irq");
    // A register write may end the request one edge later, so it is exempt
    chk_irq_hold: assert property (irq && !wc && !$past(wc) |=> irq)
        else $error("irq dropped without a write");
    chk_status_rsvd: assert property (
        read && !waitrequest && address == 8'h08 |-> readdata[31:20] == 12'h000)
        else $error("status reserved bits not zero");
    chk_enable_fixed: assert property (
        read && !waitrequest && address == 8'h04 |-> readdata[19:17] == 3'h7)
        else $error("fixed enable bits not one");
    cover property ($rose(irq));
    cover property (wc && address == 8'h0C);
    cover property (read && !waitrequest && address == 8'h08);
endmodule
bind frontend_irq_logic frontend_irq_asserts chk (.clk(clk), .rst_n(rst_n),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .irq(irq), .rx_end_evt(rx_end_evt),
    .idle_evt(idle_evt), .own_field_on_evt(own_field_on_evt),
    .timer_zero_evt(timer_zero_evt), .frame_start_seen_evt(frame_start_seen_evt),
    .temp_fault_evt(temp_fault_evt), .general_error_evt(general_error_evt),
    .nvm_program_fail_evt(nvm_program_fail_evt),
    .low_power_card_detect_evt(low_power_card_detect_evt));
`default_nettype wire

// ---- tb/host_irq_watch.sv ----
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Host side: counts interrupt requests seen on the pin
// ----------------------------------------
module host_irq_watch (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic irq,
    output int rises
);
    logic irq_q;
    // Edge count only; the host never clears, the bench plays software
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
            rises <= 0;
        end else begin
            irq_q <= irq;
            if (irq && !irq_q) rises <= rises + 1;
        end
    end
endmodule
`default_nettype wire

// ---- tb/frontend_irq_logic_tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module frontend_irq_logic_tb_top;
    typedef struct packed {logic [4:0] b; logic en; logic ex;} row_t;
    logic clk, rst_n, read, write, irq, waitrequest;
    logic [7:0] address;
    logic [31:0] writedata, readdata, q;
    logic [1:0] response;
    logic [19:0] ev;
    logic [3:0] be;
    logic [2:0] xst;
    int bad_count, checks_done, rises, rises_exp;
    row_t rows [21] = '{'{0,1,1}, '{1,1,1}, '{2,1,1}, '{3,1,1}, '{4,1,1}, '{6,1,1},
        '{7,1,1}, '{8,1,1}, '{9,1,1}, '{10,1,1}, '{11,0,0}, '{11,1,1}, '{12,1,1},
        '{13,1,1}, '{14,1,1}, '{15,1,1}, '{16,0,0}, '{16,1,1}, '{17,0,1}, '{18,0,1},
        '{19,0,1}};
    frontend_irq_logic dut (.clk(clk), .rst_n(rst_n), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(be), .readdata(readdata),
        .response(response), .waitrequest(waitrequest), .rx_end_evt(ev[0]),
        .tx_end_evt(ev[1]), .idle_evt(ev[2]), .modulation_found_evt(ev[3]),
        .card_activated_evt(ev[4]), .ext_field_off_evt(ev[6]), .ext_field_on_evt(ev[7]),
        .own_field_off_evt(ev[8]), .own_field_on_evt(ev[9]),
        .field_activity_fault_evt(ev[10]), .timer_zero_evt(ev[11]), .timer_one_evt(ev[12]),
        .timer_two_evt(ev[13]), .frame_start_seen_evt(ev[14]), .subcarrier_seen_evt(ev[15]),
        .temp_fault_evt(ev[16]), .general_error_evt(ev[17]), .nvm_program_fail_evt(ev[18]),
        .low_power_card_detect_evt(ev[19]), .xcv_state(xst), .irq(irq));
    host_irq_watch host (.clk(clk), .rst_n(rst_n), .irq(irq), .rises(rises));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checks_done++;
        if (s !== e) begin
            $display("MISMATCH %s expected %h seen %h", n, e, s);
            bad_count++;
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Holds the request until waitrequest is seen low; idles one edge after
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        read <= !w;
        write <= w;
        address <= a;
        writedata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 40);
        q = readdata;
        if (n >= 40) bad_count++;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
        bus(1'b0, a, 32'h0000_0000);
        chk(n, e, q);
    endtask
    task automatic pulse(input logic [19:0] m);
        ev <= m;
        tick(1);
        ev <= 20'h0_0000;
        tick(3);
    endtask
    task automatic end_sim;
        if (bad_count == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // ----------------------------------------
    // Stimulus
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #200000;
        bad_count++;
        end_sim;
    end
    initial begin
        {rst_n, read, write, address, writedata, ev, xst} = '0;
        {bad_count, checks_done, rises_exp} = '0;
        be = 4'hF;
        tick(6);
        rst_n <= 1'b1;
        rd(8'h04, 32'h000E_0000, "enable reset");
        rd(8'h08, 32'h0000_0000, "status reset");
        bus(1'b1, 8'h04, 32'hFFFF_FFFF);
        rd(8'h04, 32'h000F_FFFF, "enable rw");
        bus(1'b1, 8'h08, 32'hFFFF_FFFF);
        rd(8'h08, 32'h0000_0000, "status ro");
        rd(8'hF0, 32'h0000_0000, "unmapped data");
        chk("unmapped resp", 32'h0000_0002, {30'h0, response});
        foreach (rows[i]) begin
            bus(1'b1, 8'h04, rows[i].en ? 32'h0001_FFFF : 32'h0000_0000);
            pulse(20'h0_0001 << rows[i].b);
            chk("irq", {31'h0, rows[i].ex}, {31'h0, irq});
            rd(8'h08, 32'h0000_0001 << rows[i].b, "status bit");
            bus(1'b1, 8'h0C, 32'h0000_0001 << rows[i].b);
            tick(1);
            chk("irq cleared", 32'h0000_0000, {31'h0, irq});
            rises_exp += rows[i].ex;
        end
        chk("irq rises", rises_exp, rises);
        bus(1'b1, 8'h04, 32'h0000_0000);
        be <= 4'h2;
        bus(1'b1, 8'h04, 32'hFFFF_FFFF);
        be <= 4'hF;
        rd(8'h04, 32'h000E_FF00, "enable lanes");
        bus(1'b1, 8'h04, 32'h0001_FFFF);
        pulse(20'h0_0003);
        bus(1'b1, 8'h0C, 32'h0000_0001);
        tick(1);
        chk("irq held", 32'h0000_0001, {31'h0, irq});
        bus(1'b1, 8'h0C, 32'h0000_0002);
        tick(1);
        chk("irq released", 32'h0000_0000, {31'h0, irq});
        xst <= 3'h5;
        tick(2);
        rd(8'h08, 32'h0000_0000, "no trigger");
        bus(1'b1, 8'h10, 32'h0000_0040);
        rd(8'h10, 32'h0000_0040, "trigger select");
        xst <= 3'h1;
        tick(1);
        xst <= 3'h2;
        tick(2);
        rd(8'h08, 32'h0000_0020, "state change");
        bus(1'b1, 8'h0C, 32'h0000_0020);
        xst <= 3'h3;
        tick(2);
        rd(8'h08, 32'h0000_0000, "unselected state");
        pulse(20'h0_0800);
        chk("irq before reset", 32'h0000_0001, {31'h0, irq});
        rst_n <= 1'b0;
        tick(2);
        chk("irq in reset", 32'h0000_0000, {31'h0, irq});
        rst_n <= 1'b1;
        rd(8'h04, 32'h000E_0000, "enable after reset");
        rd(8'h08, 32'h0000_0000, "status after reset");
        rd(8'h10, 32'h0000_0000, "trigger after reset");
        chk("irq after reset", 32'h0000_0000, {31'h0, irq});
        end_sim;
    end
endmodule
`default_nettype wire
